/* verilog/low_voltage_detect_control.sv */
`timescale 1ns/10ps
`default_nettype none
module low_voltage_detect_control (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       detector_on,
  input  wire logic       detect_source_select,
  input  wire logic       detect_action_select,
  input  wire logic [3:0] levelSelIn,
  input  wire logic       levelSelWr,
  input  wire logic       maskSet,
  input  wire logic       maskClr,
  input  wire logic       reqClr,
  input  wire logic       causeClr,
  input  wire logic       supplyBelow,
  input  wire logic       senseBelow,
  output logic            level_compare_flag,
  output logic            detect_irq_mask,
  output logic            detect_irq_request_flag,
  output logic            low_voltage_irq,
  output logic            lvdReset,
  output logic            undervoltage_reset_cause,
  output logic [3:0]      detectLevel,
  output logic            useExternal,
  output logic            detectActive
);
  // Synchronised comparator outputs
  logic       supplySync;
  logic       senseSync;
  logic       below;
  // Control group
  logic       on_q;
  logic       on_d;
  logic [3:0] lvl_q;
  logic [3:0] lvl_d;
  // Comparison group
  logic       flag_q;
  logic       flag_d;
  // Event group
  logic       irq_q;
  logic       irq_d;
  logic       rst_q;
  logic       rst_d;
  logic       fall;
  logic       offLow;
  // Software flag group
  logic       mask_q;
  logic       mask_d;
  logic       req_q;
  logic       req_d;
  // Reset cause group
  logic       cause_q;
  logic       cause_d;

  // Sticky flag update; a hardware set wins over a clear in the same cycle
  function automatic logic sticky(input logic setEv, input logic clrEv, input logic cur);
    sticky = setEv | (cur & ~clrEv);
  endfunction

  lvd_sync uSupply (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn (supplyBelow),
    .syncOut (supplySync)
  );

  lvd_sync uSense (
    .ref_clk (ref_clk),
    .rst     (rst),
    .asyncIn (senseBelow),
    .syncOut (senseSync)
  );

  // Comparator source mux after sync so a source switch never glitches the flag
  assign below = detect_source_select ? senseSync : supplySync;

  // Control group: enable and level field
  always_comb begin
    on_d  = detector_on;
    lvl_d = levelSelWr ? levelSelIn : lvl_q;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      on_q  <= 1'b0;
      lvl_q <= lvd_pkg::LevelReset;
    end else begin
      on_q  <= on_d;
      lvl_q <= lvl_d;
    end
  end

  // Comparison group: result only while enabled
  always_comb begin
    flag_d = on_q & below;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Event group: crossing and switch-off while below
  always_comb begin
    fall   = on_q & ~flag_q & below;
    offLow = on_q & ~detector_on & below;
    irq_d  = (fall & ~detect_action_select) | offLow;
    rst_d  = fall & detect_action_select;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      rst_q <= rst_d;
    end
  end

  // Software flag group; the detector's own reset masks the irq too
  always_comb begin
    mask_d = sticky(maskSet | rst_q, maskClr, mask_q);
    req_d  = sticky(irq_d, reqClr, req_q);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_q <= 1'b1;
      req_q  <= 1'b0;
    end else begin
      mask_q <= mask_d;
      req_q  <= req_d;
    end
  end

  // Reset cause group
  always_comb begin
    cause_d = sticky(rst_q, causeClr, cause_q);
  end

  // Cause survives its own reset pulse; software must clear it once after power-up
  always_ff @(posedge ref_clk) begin
    cause_q <= cause_d;
  end

  assign level_compare_flag       = flag_q;
  assign detect_irq_mask          = mask_q;
  assign detect_irq_request_flag  = req_q;
  assign low_voltage_irq          = irq_q & ~mask_q;
  assign lvdReset                 = rst_q;
  assign undervoltage_reset_cause = cause_q;
  assign detectLevel              = lvl_q;
  assign useExternal              = detect_source_select;
  assign detectActive             = on_q;

  flag_tracks_a: assert property (@(posedge ref_clk) disable iff (rst)
    on_q && below |=> flag_q) else $error("flag not set");
  off_no_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    !on_q |=> !flag_q) else $error("flag while off");
  irq_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
    fall && !detect_action_select |=> irq_q && !rst_q) else $error("no irq");
  reset_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
    fall && detect_action_select |=> rst_q && !irq_q) else $error("no reset");
  off_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    offLow |=> irq_q && req_q) else $error("disable event lost");
  mask_on_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    rst_q |=> mask_q) else $error("mask not set by detector reset");
  irq_masked_a: assert property (@(posedge ref_clk) disable iff (rst)
    mask_q |-> !low_voltage_irq) else $error("irq passed the mask");
  req_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    reqClr && !irq_d |=> !req_q) else $error("request flag not cleared");
  rst_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    rst_q |=> !rst_q) else $error("reset pulse too long");
  cause_rec_a: assert property (@(posedge ref_clk) disable iff (rst)
    rst_q |=> cause_q) else $error("cause missing");
  src_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
    detect_source_select |-> below == senseSync) else $error("bad source");
  req_set_a: assert property (@(posedge ref_clk) disable iff (rst)
    irq_q |-> req_q) else $error("request flag missed");
  lvl_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    levelSelWr |=> lvl_q == $past(levelSelIn)) else $error("level not stored");
endmodule
`default_nettype wire

/* verilog/lvd_pkg.sv */
// Contract
// - Source-select bit 2 set compares the external sense input, not supply.
// - Action-select bit 1 clear: a detected crossing raises an interrupt request.
// - Detector-on bit 7 enables detection; cleared means no detection.
// - Bit 0 shows the current comparison result for software.
// - Writing 00h or clearing only detector-on stops detection.
// - Any reset forces the detector interrupt mask to 1.
// - In interrupt mode a crossing asserts the irq and sets flags.
// - Disabling while input is below level asserts the irq and request flag.
// - Action-select set: a detected crossing generates an internal reset.
// - A detector reset is recorded in bit 0 of the reset cause register.
// - Supply monitoring level comes from a four-bit field, bits 3 to 0.
package lvd_pkg;
  localparam int          CtlOnBit      = 7;
  localparam int          CtlSrcBit     = 2;
  localparam int          CtlActBit     = 1;
  localparam int          CtlFlagBit    = 0;
  localparam int          IrqReqBit     = 1;
  localparam int          CauseLvdBit   = 0;
  localparam logic [7:0]  CtlReset      = 8'h00;
  localparam logic [3:0]  LevelReset    = 4'h0;
  localparam int          SyncStages    = 3;
  localparam int          ClkPeriodPs   = 5000;
  localparam int          SettleTimeNs  = 10000;
  localparam int          SettleCycles  = (SettleTimeNs * 1000) / ClkPeriodPs;
endpackage

/* verilog/lvd_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module lvd_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic [lvd_pkg::SyncStages-1:0] stage_q;
  logic [lvd_pkg::SyncStages-1:0] stage_d;
  logic                           out_q;
  logic                           out_d;

  // Stage 0 feeds stage 1 only; a change counts when stages 1 and 2 agree
  always_comb begin
    stage_d = {stage_q[lvd_pkg::SyncStages-2:0], asyncIn};
    out_d   = (stage_q[1] == stage_q[2]) ? stage_q[2] : out_q;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage_q <= '0;
      out_q   <= 1'b0;
    end else begin
      stage_q <= stage_d;
      out_q   <= out_d;
    end
  end

  assign syncOut = out_q;
endmodule
`default_nettype wire

/* tb/cmp_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cmp_model #(
  parameter logic [3:0] SenseRef = 4'h8
) (
  input  wire logic [3:0] supplyV,
  input  wire logic [3:0] senseV,
  input  wire logic [3:0] level,
  output logic            supplyBelow,
  output logic            senseBelow
);
  // No hysteresis: the bench never parks a level near the threshold
  assign supplyBelow = supplyV < level;
  assign senseBelow  = senseV < SenseRef;
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, msg) \
  begin \
    comparisons++; \
    if ((a) !== (b)) begin \
      failCount++; \
      $display("MISMATCH t=%0t %s", $time, msg); \
    end \
  end
module tb;
  logic ref_clk = 0, rst = 1, detector_on = 0, detect_source_select = 0;
  logic detect_action_select = 0, levelSelWr = 0, maskSet = 0, maskClr = 0;
  logic reqClr = 0, causeClr = 0, supplyBelow, senseBelow, useExternal;
  logic level_compare_flag, detect_irq_mask, detect_irq_request_flag;
  logic low_voltage_irq, lvdReset, undervoltage_reset_cause, detectActive;
  logic [3:0] levelSelIn = 4'h8, supplyV = 4'hf, senseV = 4'hf, detectLevel;
  logic [4:0] rows [5] = '{5'b10101, 5'b10010, 5'b11011, 5'b11100, 5'b00110};
  int failCount = 0, comparisons = 0, irqCnt = 0, rstCnt = 0, cycles = 0;
  cmp_model model (.supplyV, .senseV, .level(detectLevel), .supplyBelow, .senseBelow);
  low_voltage_detect_control DUT (.ref_clk, .rst, .detector_on, .detect_source_select,
    .detect_action_select, .levelSelIn, .levelSelWr, .maskSet, .maskClr, .reqClr,
    .causeClr, .supplyBelow, .senseBelow, .level_compare_flag, .detect_irq_mask,
    .detect_irq_request_flag, .low_voltage_irq, .lvdReset, .undervoltage_reset_cause,
    .detectLevel, .useExternal, .detectActive);
  initial forever #2.5 ref_clk = ~ref_clk;
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    irqCnt += (low_voltage_irq === 1'b1);
    rstCnt += (lvdReset === 1'b1);
    cycles++;
    // Whole run needs about 83 cycles
    if (cycles == 1000) begin
      failCount++;
      end_sim();
    end
  end
  initial begin
    tick(8);
    `CHK(detect_irq_mask, 1'b1, "mask in reset")
    rst = 0; causeClr = 1; levelSelWr = 1; tick(1);
    causeClr = 0; levelSelWr = 0; tick(1);
    `CHK(detectLevel, 4'h8, "level field")
    for (int i = 0; i < 5; i++) begin
      {detector_on, detect_source_select} = rows[i][4:3];
      supplyV = rows[i][2] ? 4'h0 : 4'hf;
      senseV = rows[i][1] ? 4'h0 : 4'hf;
      tick(6);
      `CHK(level_compare_flag, rows[i][0], "compare flag")
      `CHK(useExternal, rows[i][3], "source")
      `CHK(detectActive, rows[i][4], "enable")
    end
    // Mask stays set until enable has settled and the stale request is gone
    supplyV = 4'hf; detect_source_select = 0; detector_on = 1; tick(6);
    reqClr = 1; maskClr = 1; tick(1);
    reqClr = 0; maskClr = 0; irqCnt = 0; supplyV = 4'h0; tick(8);
    `CHK(irqCnt, 1, "irq count")
    `CHK(rstCnt, 0, "no reset in irq mode")
    `CHK(detect_irq_request_flag, 1'b1, "request flag")
    reqClr = 1; tick(1);
    reqClr = 0; tick(1);
    `CHK(detect_irq_request_flag, 1'b0, "request cleared")
    detector_on = 0; tick(8);
    `CHK(irqCnt, 2, "irq on disable below")
    `CHK(level_compare_flag, 1'b0, "stopped")
    supplyV = 4'hf; detect_action_select = 1; detector_on = 1; tick(6);
    causeClr = 1; tick(1);
    causeClr = 0; irqCnt = 0; rstCnt = 0; supplyV = 4'h0; tick(8);
    `CHK(rstCnt, 1, "reset pulse")
    `CHK(irqCnt, 0, "no irq in reset mode")
    `CHK(undervoltage_reset_cause, 1'b1, "cause bit")
    `CHK(detect_irq_mask, 1'b1, "mask set by detector reset")
    maskClr = 1; tick(1);
    maskClr = 0; tick(1);
    `CHK(detect_irq_mask, 1'b0, "mask released")
    rst = 1; tick(1);
    `CHK(detect_irq_mask, 1'b1, "mask on second reset")
    end_sim();
  end
endmodule
`default_nettype wire
